// [pkg/bod_defines.vh]
// Constants for the opcode decoder tail
`ifndef BOD_DEFINES_VH
`define BOD_DEFINES_VH

// ==========================================
// Operand field positions
`define BOD_DST_HI 5
`define BOD_DST_LO 3
`define BOD_SRC_HI 2
`define BOD_SRC_LO 0
`define BOD_PAIR_HI 5
`define BOD_PAIR_LO 4

// ==========================================
// Register operand codes
`define BOD_REG_B   3'h0
`define BOD_REG_C   3'h1
`define BOD_REG_D   3'h2
`define BOD_REG_E   3'h3
`define BOD_REG_H   3'h4
`define BOD_REG_L   3'h5
`define BOD_REG_MEM 3'h6
`define BOD_REG_A   3'h7

// ==========================================
// Register pair codes
`define BOD_PAIR_BC 2'h0
`define BOD_PAIR_DE 2'h1
`define BOD_PAIR_HL 2'h2
`define BOD_PAIR_SP 2'h3

// ==========================================
// Return condition codes
`define BOD_CC_NOT_ZERO 3'h0
`define BOD_CC_ZERO     3'h1
`define BOD_CC_NO_CARRY 3'h2
`define BOD_CC_CARRY    3'h3
`define BOD_CC_PAR_ODD  3'h4
`define BOD_CC_PAR_EVEN 3'h5
`define BOD_CC_PLUS     3'h6
`define BOD_CC_MINUS    3'h7

// ==========================================
// Opcode masks and match values
`define BOD_MASK_GRP    8'hC7
`define BOD_MASK_PAIR   8'hCF
`define BOD_MASK_ALU    8'hC0
`define BOD_VAL_RET_CC  8'hC0
`define BOD_VAL_BINC    8'h04
`define BOD_VAL_BDEC    8'h05
`define BOD_VAL_PINC    8'h03
`define BOD_VAL_PDEC    8'h0B
`define BOD_VAL_PADD    8'h09
`define BOD_VAL_RST     8'hC7
`define BOD_VAL_ALU_REG 8'h80
`define BOD_VAL_ALU_IMM 8'hC6
`define BOD_VAL_ROT_SPC 8'h07
`define BOD_OPC_RET     8'hC9
`define BOD_OPC_IN      8'hDB
`define BOD_OPC_OUT     8'hD3
`define BOD_OPC_EI      8'hFB
`define BOD_OPC_DI      8'hF3
`define BOD_OPC_NOP     8'h00
`define BOD_OPC_HALT    8'h76
`define BOD_OPC_RDMASK  8'h20
`define BOD_OPC_SETMASK 8'h30

// ==========================================
// Operation classes; groups carry the sub-op in low bits
`define BOD_GRP_ALU_REG 3'h1
`define BOD_GRP_ALU_IMM 3'h2
`define BOD_GRP_ROT_SPC 3'h3
`define BOD_OP_OTHER    6'h00
`define BOD_OP_NOP      6'h20
`define BOD_OP_HALT     6'h21
`define BOD_OP_RET_ALW  6'h22
`define BOD_OP_RET_CC   6'h23
`define BOD_OP_RESTART  6'h24
`define BOD_OP_PORT_IN  6'h25
`define BOD_OP_PORT_OUT 6'h26
`define BOD_OP_BYTE_INC 6'h27
`define BOD_OP_BYTE_DEC 6'h28
`define BOD_OP_PAIR_INC 6'h29
`define BOD_OP_PAIR_DEC 6'h2A
`define BOD_OP_PAIR_ADD 6'h2B
`define BOD_OP_INT_EN   6'h2C
`define BOD_OP_INT_DIS  6'h2D
`define BOD_OP_RD_MASK  6'h2E
`define BOD_OP_SET_MASK 6'h2F

// ==========================================
// Clock-cycle counts
`define BOD_CYC_ZERO    5'h00
`define BOD_CYC_SHORT   5'h04
`define BOD_CYC_HALT    5'h05
`define BOD_CYC_PAIR    5'h06
`define BOD_CYC_MEMALU  5'h07
`define BOD_CYC_LONG    5'h0A
`define BOD_CYC_RET_NO  5'h06
`define BOD_CYC_RET_YES 5'h0C
`define BOD_CYC_RST     5'h0C

`endif

// [design/bod_cond_eval.v]
// Condition test for conditional returns
`timescale 1ns/1ps

module bod_cond_eval (
  input  wire [2:0] condSel,
  input  wire       flagZero,
  input  wire       flagCarry,
  input  wire       flagParity,
  input  wire       flagSign,
  output reg        condTrue
);
`include "bod_defines.vh"

  // ==========================================
  // Flag select
  always @* begin
    case (condSel)
      `BOD_CC_NOT_ZERO: condTrue = ~flagZero;
      `BOD_CC_ZERO:     condTrue = flagZero;
      `BOD_CC_NO_CARRY: condTrue = ~flagCarry;
      `BOD_CC_CARRY:    condTrue = flagCarry;
      `BOD_CC_PAR_ODD:  condTrue = ~flagParity;
      `BOD_CC_PAR_EVEN: condTrue = flagParity;
      `BOD_CC_PLUS:     condTrue = ~flagSign;
      default:          condTrue = flagSign;
    endcase
  end

endmodule

// [design/bod_decoder.v]
// Single-byte opcode decoder, second half of the set
`timescale 1ns/1ps

module bod_decoder (
  input  wire       mclk,
  input  wire       rst,
  input  wire       opValid,
  input  wire [7:0] opByte,
  input  wire       flagZero,
  input  wire       flagCarry,
  input  wire       flagParity,
  input  wire       flagSign,
  output reg        decValid_r,
  output reg  [5:0] opClass_r,
  output reg  [2:0] dstReg_r,
  output reg  [2:0] srcReg_r,
  output reg  [1:0] pairSel_r,
  output reg        memOperand_r,
  output reg        immByte_r,
  output reg        condTaken_r,
  output reg  [2:0] restartVec_r,
  output reg  [4:0] cycles_r,
  output reg        unknownOp_r
);
`include "bod_defines.vh"

  // ==========================================
  // Helpers
  function match;
    input [7:0] op;
    input [7:0] mask;
    input [7:0] val;
    begin
      match = ((op & mask) == val);
    end
  endfunction

  // Memory operand code in a register field
  function isMem;
    input [2:0] fld;
    begin
      isMem = (fld == `BOD_REG_MEM);
    end
  endfunction

  // Short count for register operand, longer for memory
  function [4:0] pickCyc;
    input [2:0] fld;
    input [4:0] regCyc;
    input [4:0] memCyc;
    begin
      pickCyc = isMem(fld) ? memCyc : regCyc;
    end
  endfunction

  // ==========================================
  // Field extraction
  wire [2:0] dstFld = opByte[`BOD_DST_HI:`BOD_DST_LO];
  wire [2:0] srcFld = opByte[`BOD_SRC_HI:`BOD_SRC_LO];
  wire [1:0] pairFld = opByte[`BOD_PAIR_HI:`BOD_PAIR_LO];
  wire       condTrue;

  bod_cond_eval uCond (
    .condSel    (dstFld),
    .flagZero   (flagZero),
    .flagCarry  (flagCarry),
    .flagParity (flagParity),
    .flagSign   (flagSign),
    .condTrue   (condTrue)
  );

  // ==========================================
  // Decode
  reg [5:0] opClass_nxt;
  reg [2:0] dstReg_nxt;
  reg [2:0] srcReg_nxt;
  reg [1:0] pairSel_nxt;
  reg       memOperand_nxt;
  reg       immByte_nxt;
  reg       condTaken_nxt;
  reg [2:0] restartVec_nxt;
  reg [4:0] cycles_nxt;
  reg       unknownOp_nxt;

  always @* begin
    opClass_nxt    = `BOD_OP_OTHER;
    dstReg_nxt     = `BOD_REG_A;
    srcReg_nxt     = `BOD_REG_A;
    pairSel_nxt    = `BOD_PAIR_BC;
    memOperand_nxt = 1'b0;
    immByte_nxt    = 1'b0;
    condTaken_nxt  = 1'b0;
    restartVec_nxt = 3'h0;
    cycles_nxt     = `BOD_CYC_ZERO;
    unknownOp_nxt  = 1'b0;
    if (opByte == `BOD_OPC_RET) begin
      opClass_nxt   = `BOD_OP_RET_ALW;
      condTaken_nxt = 1'b1;
      cycles_nxt    = `BOD_CYC_LONG;
    end else if (match(opByte, `BOD_MASK_GRP, `BOD_VAL_RET_CC)) begin
      opClass_nxt   = `BOD_OP_RET_CC;
      condTaken_nxt = condTrue;
      cycles_nxt    = condTrue ? `BOD_CYC_RET_YES : `BOD_CYC_RET_NO;
    end else if (match(opByte, `BOD_MASK_GRP, `BOD_VAL_RST)) begin
      opClass_nxt    = `BOD_OP_RESTART;
      restartVec_nxt = dstFld;
      cycles_nxt     = `BOD_CYC_RST;
    end else if (opByte == `BOD_OPC_IN) begin
      opClass_nxt = `BOD_OP_PORT_IN;
      immByte_nxt = 1'b1;
      cycles_nxt  = `BOD_CYC_LONG;
    end else if (opByte == `BOD_OPC_OUT) begin
      opClass_nxt = `BOD_OP_PORT_OUT;
      immByte_nxt = 1'b1;
      cycles_nxt  = `BOD_CYC_LONG;
    end else if (opByte == `BOD_OPC_EI) begin
      opClass_nxt = `BOD_OP_INT_EN;
      cycles_nxt  = `BOD_CYC_SHORT;
    end else if (opByte == `BOD_OPC_DI) begin
      opClass_nxt = `BOD_OP_INT_DIS;
      cycles_nxt  = `BOD_CYC_SHORT;
    end else if (opByte == `BOD_OPC_NOP) begin
      opClass_nxt = `BOD_OP_NOP;
      cycles_nxt  = `BOD_CYC_SHORT;
    end else if (opByte == `BOD_OPC_HALT) begin
      // Checked before anything else in the 01 quadrant
      opClass_nxt = `BOD_OP_HALT;
      cycles_nxt  = `BOD_CYC_HALT;
    end else if (opByte == `BOD_OPC_RDMASK) begin
      opClass_nxt = `BOD_OP_RD_MASK;
      cycles_nxt  = `BOD_CYC_SHORT;
    end else if (opByte == `BOD_OPC_SETMASK) begin
      opClass_nxt = `BOD_OP_SET_MASK;
      cycles_nxt  = `BOD_CYC_SHORT;
    end else if (match(opByte, `BOD_MASK_GRP, `BOD_VAL_BINC)) begin
      opClass_nxt    = `BOD_OP_BYTE_INC;
      dstReg_nxt     = dstFld;
      srcReg_nxt     = dstFld;
      memOperand_nxt = isMem(dstFld);
      cycles_nxt     = pickCyc(dstFld, `BOD_CYC_SHORT, `BOD_CYC_LONG);
    end else if (match(opByte, `BOD_MASK_GRP, `BOD_VAL_BDEC)) begin
      opClass_nxt    = `BOD_OP_BYTE_DEC;
      dstReg_nxt     = dstFld;
      srcReg_nxt     = dstFld;
      memOperand_nxt = isMem(dstFld);
      cycles_nxt     = pickCyc(dstFld, `BOD_CYC_SHORT, `BOD_CYC_LONG);
    end else if (match(opByte, `BOD_MASK_PAIR, `BOD_VAL_PINC)) begin
      opClass_nxt = `BOD_OP_PAIR_INC;
      pairSel_nxt = pairFld;
      cycles_nxt  = `BOD_CYC_PAIR;
    end else if (match(opByte, `BOD_MASK_PAIR, `BOD_VAL_PDEC)) begin
      opClass_nxt = `BOD_OP_PAIR_DEC;
      pairSel_nxt = pairFld;
      cycles_nxt  = `BOD_CYC_PAIR;
    end else if (match(opByte, `BOD_MASK_PAIR, `BOD_VAL_PADD)) begin
      // Destination is always the HL pair
      opClass_nxt = `BOD_OP_PAIR_ADD;
      pairSel_nxt = pairFld;
      cycles_nxt  = `BOD_CYC_LONG;
    end else if (match(opByte, `BOD_MASK_GRP, `BOD_VAL_ROT_SPC)) begin
      // Rotates on codes 0-3, accumulator specials on 4-7
      opClass_nxt = {`BOD_GRP_ROT_SPC, dstFld};
      cycles_nxt  = `BOD_CYC_SHORT;
    end else if (match(opByte, `BOD_MASK_ALU, `BOD_VAL_ALU_REG)) begin
      // Sub-op order: add, adc, sub, sbb, and, xor, or, cmp
      opClass_nxt    = {`BOD_GRP_ALU_REG, dstFld};
      srcReg_nxt     = srcFld;
      memOperand_nxt = isMem(srcFld);
      cycles_nxt     = pickCyc(srcFld, `BOD_CYC_SHORT, `BOD_CYC_MEMALU);
    end else if (match(opByte, `BOD_MASK_GRP, `BOD_VAL_ALU_IMM)) begin
      opClass_nxt = {`BOD_GRP_ALU_IMM, dstFld};
      immByte_nxt = 1'b1;
      cycles_nxt  = `BOD_CYC_MEMALU;
    end else begin
      // Opcodes of the first half pass on flagged, count zero
      unknownOp_nxt = 1'b1;
      dstReg_nxt    = dstFld;
      srcReg_nxt    = srcFld;
      pairSel_nxt   = pairFld;
    end
  end

  // ==========================================
  // Output registers
  // Decoded fields held until the next opcode so the sequencer may read at leisure; decValid_r follows opValid every cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      decValid_r   <= 1'b0;
      opClass_r    <= `BOD_OP_OTHER;
      dstReg_r     <= `BOD_REG_B;
      srcReg_r     <= `BOD_REG_B;
      pairSel_r    <= `BOD_PAIR_BC;
      memOperand_r <= 1'b0;
      immByte_r    <= 1'b0;
      condTaken_r  <= 1'b0;
      restartVec_r <= 3'h0;
      cycles_r     <= `BOD_CYC_ZERO;
      unknownOp_r  <= 1'b0;
    end else begin
      decValid_r <= opValid;
      if (opValid) begin
        opClass_r    <= opClass_nxt;
        dstReg_r     <= dstReg_nxt;
        srcReg_r     <= srcReg_nxt;
        pairSel_r    <= pairSel_nxt;
        memOperand_r <= memOperand_nxt;
        immByte_r    <= immByte_nxt;
        condTaken_r  <= condTaken_nxt;
        restartVec_r <= restartVec_nxt;
        cycles_r     <= cycles_nxt;
        unknownOp_r  <= unknownOp_nxt;
      end
    end
  end

endmodule

// [sim/bod_decoder_monitor.sv]
// Port assertions for the opcode decoder
`timescale 1ns/1ps
// ==========================================
// Checker
module bod_decoder_monitor (
  input wire       mclk,
  input wire       rst,
  input wire       opValid,
  input wire [7:0] opByte,
  input wire       flagZero,
  input wire       decValid_r,
  input wire [5:0] opClass_r,
  input wire [2:0] dstReg_r,
  input wire [2:0] srcReg_r,
  input wire [1:0] pairSel_r,
  input wire       memOperand_r,
  input wire       immByte_r,
  input wire       condTaken_r,
  input wire [4:0] cycles_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  vld_pulse_a: assert property (1'b1 |=> decValid_r == $past(opValid)) else $error("decode strobe wrong");
  out_hold_a: assert property (!opValid |=> $stable({opClass_r, cycles_r, dstReg_r, srcReg_r}))
    else $error("outputs moved without opcode");
  ret_cnt_a: assert property (opValid && opByte[7:6] == 2'b11 && opByte[2:0] == 3'h0
    |=> opClass_r == 6'h23 && cycles_r == (condTaken_r ? 5'h0C : 5'h06)) else $error("return count wrong");
  ret_zero_a: assert property (opValid && opByte == 8'hC8 |=> condTaken_r == $past(flagZero))
    else $error("zero return test wrong");
  ret_alw_a: assert property (opValid && opByte == 8'hC9
    |=> opClass_r == 6'h22 && cycles_r == 5'h0A && condTaken_r) else $error("return count wrong");
  byte_cnt_a: assert property (opValid && (opByte & 8'hC6) == 8'h04
    |=> dstReg_r == $past(opByte[5:3]) && memOperand_r == ($past(opByte[5:3]) == 3'h6)
    && cycles_r == (memOperand_r ? 5'h0A : 5'h04)) else $error("byte step wrong");
  pair_cnt_a: assert property (opValid && (opByte & 8'hC7) == 8'h03
    |=> cycles_r == 5'h06 && pairSel_r == $past(opByte[5:4])) else $error("pair step wrong");
  pair_add_a: assert property (opValid && (opByte & 8'hCF) == 8'h09
    |=> opClass_r == 6'h2B && cycles_r == 5'h0A && pairSel_r == $past(opByte[5:4])) else $error("pair add wrong");
  alu_reg_a: assert property (opValid && opByte[7:6] == 2'b10
    |=> opClass_r == {3'h1, $past(opByte[5:3])} && srcReg_r == $past(opByte[2:0])
    && cycles_r == (srcReg_r == 3'h6 ? 5'h07 : 5'h04)) else $error("alu decode wrong");
  alu_imm_a: assert property (opValid && (opByte & 8'hC7) == 8'hC6
    |=> immByte_r && cycles_r == 5'h07 && opClass_r == {3'h2, $past(opByte[5:3])}) else $error("immediate wrong");
  rot_cnt_a: assert property (opValid && (opByte & 8'hE7) == 8'h07
    |=> cycles_r == 5'h04 && opClass_r == {3'h3, $past(opByte[5:3])}) else $error("rotate wrong");
endmodule
bind bod_decoder bod_decoder_monitor mon (.mclk, .rst, .opValid, .opByte, .flagZero, .decValid_r, .opClass_r,
  .dstReg_r, .srcReg_r, .pairSel_r, .memOperand_r, .immByte_r, .condTaken_r, .cycles_r);

// [sim/bod_fetch_model.sv]
// Fetch unit model feeding opcode bytes and flags
`timescale 1ns/1ps
// ==========================================
// Model
module bod_fetch_model (
  input  wire        mclk,
  output logic       opValid,
  output logic [7:0] opByte,
  output logic       flagZero,
  output logic       flagCarry,
  output logic       flagParity,
  output logic       flagSign
);
  initial begin
    opValid = 1'b0;
    opByte = 8'hA5;
    {flagSign, flagParity, flagCarry, flagZero} = 4'h0;
  end
  // Caller sits at a falling edge; keep holds strobe for back-to-back bytes
  task send(input logic [7:0] b, input logic [3:0] f, input bit keep);
    opValid = 1'b1;
    opByte = b;
    {flagSign, flagParity, flagCarry, flagZero} = f;
    @(posedge mclk);
    @(negedge mclk);
    if (!keep) begin
      opValid = 1'b0;
      // Stale byte inverted so nothing leans on a held value
      opByte = ~b;
      @(negedge mclk);
    end
  endtask
endmodule

// [sim/byte_opcode_decoder_tail_test.sv]
// Directed bench for the opcode decoder
`timescale 1ns/1ps
// ==========================================
// Bench
module byte_opcode_decoder_tail_test;
  logic mclk, rst, opValid, flagZero, flagCarry, flagParity, flagSign;
  logic [7:0] opByte;
  logic decValid_r, memOperand_r, immByte_r, condTaken_r, unknownOp_r;
  logic [5:0] opClass_r;
  logic [2:0] dstReg_r, srcReg_r, restartVec_r;
  logic [1:0] pairSel_r;
  logic [4:0] cycles_r;
  int n_errors, tests_run;
  bod_fetch_model fm (.mclk, .opValid, .opByte, .flagZero, .flagCarry, .flagParity, .flagSign);
  bod_decoder uut (.mclk, .rst, .opValid, .opByte, .flagZero, .flagCarry, .flagParity, .flagSign, .decValid_r,
    .opClass_r, .dstReg_r, .srcReg_r, .pairSel_r, .memOperand_r, .immByte_r, .condTaken_r, .restartVec_r,
    .cycles_r, .unknownOp_r);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Only the tested flag follows f, the rest oppose it
  task s_return;
    logic t;
    for (int c = 0; c < 8; c++) for (int f = 0; f < 2; f++) begin
      t = (c[0] == f[0]);
      fm.send({2'b11, c[2:0], 3'h0}, f[0] ? 4'h1 << c[2:1] : ~(4'h1 << c[2:1]), 1'b0);
      chk("cls", 8'(opClass_r), 8'h23);
      chk("cond", 8'(condTaken_r), 8'(t));
      chk("cyc", 8'(cycles_r), t ? 8'h0C : 8'h06);
    end
    fm.send(8'hC9, 4'h0, 1'b0);
    chk("cls", 8'(opClass_r), 8'h22);
    chk("cyc", 8'(cycles_r), 8'h0A);
    chk("cond", 8'(condTaken_r), 8'h01);
  endtask
  task s_bytes;
    for (int d = 0; d < 8; d++) for (int k = 0; k < 2; k++) begin
      fm.send({2'b00, d[2:0], 2'b10, k[0]}, 4'h0, 1'b0);
      chk("cls", 8'(opClass_r), k ? 8'h28 : 8'h27);
      chk("dst", 8'(dstReg_r), 8'(d));
      chk("mem", 8'(memOperand_r), 8'(d == 6));
      chk("cyc", 8'(cycles_r), d == 6 ? 8'h0A : 8'h04);
    end
  endtask
  task s_pairs;
    logic [3:0] lo [3] = '{4'h3, 4'hB, 4'h9};
    logic [7:0] cl [3] = '{8'h29, 8'h2A, 8'h2B};
    for (int p = 0; p < 4; p++) for (int t = 0; t < 3; t++) begin
      fm.send({2'b00, p[1:0], lo[t]}, 4'h0, 1'b0);
      chk("cls", 8'(opClass_r), cl[t]);
      chk("pair", 8'(pairSel_r), 8'(p));
      chk("cyc", 8'(cycles_r), t == 2 ? 8'h0A : 8'h06);
    end
  endtask
  // Strobe held high across the whole group
  task s_alu;
    for (int k = 0; k < 8; k++) for (int s = 0; s < 8; s++) begin
      fm.send({2'b10, k[2:0], s[2:0]}, 4'h0, 1'b1);
      chk("vld", 8'(decValid_r), 8'h01);
      chk("cls", 8'(opClass_r), 8'(8 + k));
      chk("src", 8'(srcReg_r), 8'(s));
      chk("mem", 8'(memOperand_r), 8'(s == 6));
      chk("cyc", 8'(cycles_r), s == 6 ? 8'h07 : 8'h04);
    end
    for (int k = 0; k < 8; k++) begin
      fm.send({2'b11, k[2:0], 3'h6}, 4'h0, k != 7);
      chk("cls", 8'(opClass_r), 8'(16 + k));
      chk("imm", 8'(immByte_r), 8'h01);
      chk("cyc", 8'(cycles_r), 8'h07);
    end
  endtask
  task s_misc;
    logic [7:0] ob [8] = '{8'hFB, 8'hF3, 8'h00, 8'h76, 8'h20, 8'h30, 8'hDB, 8'hD3};
    logic [7:0] oc [8] = '{8'h04, 8'h04, 8'h04, 8'h05, 8'h04, 8'h04, 8'h0A, 8'h0A};
    logic [7:0] ol [8] = '{8'h2C, 8'h2D, 8'h20, 8'h21, 8'h2E, 8'h2F, 8'h25, 8'h26};
    for (int k = 0; k < 8; k++) begin
      fm.send({2'b00, k[2:0], 3'h7}, 4'h0, 1'b0);
      chk("cyc", 8'(cycles_r), 8'h04);
      chk("cls", 8'(opClass_r), 8'(24 + k));
      fm.send({2'b11, k[2:0], 3'h7}, 4'h0, 1'b0);
      chk("rst", 8'(restartVec_r), 8'(k));
      chk("cyc", 8'(cycles_r), 8'h0C);
      chk("cls", 8'(opClass_r), 8'h24);
      fm.send(ob[k], 4'h0, 1'b0);
      chk("cyc", 8'(cycles_r), oc[k]);
      chk("cls", 8'(opClass_r), ol[k]);
      chk("imm", 8'(immByte_r), 8'(k > 5));
      chk("unk", 8'(unknownOp_r), 8'h00);
    end
    chk("vld", 8'(decValid_r), 8'h00);
    fm.send(8'h40, 4'h0, 1'b0);
    chk("unk", 8'(unknownOp_r), 8'h01);
    chk("cyc", 8'(cycles_r), 8'h00);
    chk("cls", 8'(opClass_r), 8'h00);
  endtask
  // Reset in mid-run clears held results
  task s_reset;
    fm.send(8'hC9, 4'h0, 1'b0);
    rst = 1'b1;
    @(negedge mclk);
    chk("cyc", 8'(cycles_r), 8'h00);
    chk("cls", 8'(opClass_r), 8'h00);
    rst = 1'b0;
    @(negedge mclk);
    fm.send(8'h3C, 4'h0, 1'b0);
    chk("cyc", 8'(cycles_r), 8'h04);
  endtask
  initial begin
    #200000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    rst = 1'b1;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    s_return;
    s_bytes;
    s_pairs;
    s_alu;
    s_misc;
    s_reset;
    tally_and_finish;
  end
endmodule
